/* File: core/adc_link_pkg.sv */
// Shared constants for the converter link: timing, widths, zero values.
// Assumes a 100 MHz system clock on both ends.
package adc_link_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int RESULT_BITS = 12;
	localparam int BIT_CNT_W = 4;
	// Most significant bit valid after start falls, in ns
	localparam int CONV_TIME_NS = 3700;
	localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
	// Internal successive-approximation step clock, nominal 4 MHz
	localparam int SAR_OSC_PERIOD_NS = 250;
	localparam int SAR_STEP_CYCLES = SAR_OSC_PERIOD_NS / CLK_PERIOD_NS;
	// Least high and low time of a start pulse, in ns
	localparam int START_PULSE_NS = 30;
	localparam int START_PULSE_CYCLES =
		(START_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Least acquisition time, in ns
	localparam int ACQ_MIN_NS = 1400;
	localparam int ACQ_MIN_CYCLES =
		(ACQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCLK_HALF_CYCLES = 5;
	localparam int TIMER_W = 12;
	localparam logic [TIMER_W-1:0] TIMER_ZERO = 12'h000;
	localparam logic [BIT_CNT_W-1:0] BIT_CNT_ZERO = 4'h0;
	localparam logic [RESULT_BITS-1:0] RESULT_ZERO = 12'h000;
endpackage

/* File: core/adc_link_if.sv */
// Link between the host and the converter: start pin, serial clock,
// three-state data pin. Resolves the data wire from its enable.
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
	logic conversion_start_pin;
	logic sclk;
	logic dout_o;
	logic dout_oe;
	logic dout_wire;
	// Floating wire reads as high for simulation
	assign dout_wire = dout_oe ? dout_o : 1'b1;
	modport device(input conversion_start_pin, input sclk,
		output dout_o, output dout_oe);
	modport host(output conversion_start_pin, output sclk,
		input dout_wire);
endinterface
`default_nettype wire

/* File: core/edge_sync.sv */
// Two-flop synchroniser with rise and fall pulses taken after it.
// Assumes an asynchronous input and the local synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_async,
	output logic o_level,
	output logic o_rise,
	output logic o_fall
);
	logic meta_ff, sync_ff, last_ff;
	logic nxt_meta, nxt_sync, nxt_last;
	always_comb begin
		nxt_meta = i_async;
		nxt_sync = meta_ff;
		nxt_last = sync_ff;
	end
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			last_ff <= 1'b0;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
			last_ff <= nxt_last;
		end
	end
	assign o_level = sync_ff;
	assign o_rise = sync_ff & ~last_ff;
	assign o_fall = ~sync_ff & last_ff;
endmodule
`default_nettype wire

/* File: core/adc_device.sv */
// Converter end: start pin decode, timed conversion, serial read-out.
// Assumes the host keeps its timing; link pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1: Start rise powers up, tracks input
// R2: Start fall holds sample, begins conversion
// R3: Converts positive minus negative into 12 bits
// R4: Negative cap to ground or negative input
// R5: Data low at start, MSB when done
// R6: MSB valid within 3.7 us of fall
// R7: Shuts down by itself after conversion
// R8: Data changes only on serial clock fall
// R9: Result shifts out MSB first
// R10: Data released after all bits out
// R11: Single rise selects first channel
// R12: Double pulse selects second channel
// R13: Host holds start high at least 1.4 us
// R14: Host lengthens high time for slow sources
// R15: Host reads all 12 bits first
// R16: Short read selects second channel next
// R17: Differential: single unipolar, double bipolar
// R18: Steps timed by internal 4 MHz oscillator
// R19: Host gives 12 rises, samples on rise
module adc_device
	import adc_link_pkg::*;
#(
	parameter bit DIFFERENTIAL = 1'b0,
	parameter int WIDTH = RESULT_BITS
) (
	// System
	input wire logic I_MCLK,
	input wire logic I_SYS_RST,
	// Link
	adc_link_if.device LINK,
	// Analog front end, sampled as codes
	input wire logic [WIDTH-1:0] I_FIRST_INPUT_CHANNEL,
	input wire logic [WIDTH-1:0] I_SECOND_INPUT_CHANNEL,
	input wire logic [WIDTH-1:0] I_POSITIVE_DIFF_INPUT,
	input wire logic [WIDTH-1:0] I_NEGATIVE_DIFF_INPUT,
	// Status
	output logic O_POWERED,
	output logic O_TRACKING,
	output logic O_SECOND_SELECT,
	output logic O_BIPOLAR
);
	typedef enum {ST_SHUTDOWN, ST_TRACK, ST_CONVERT, ST_SHIFT} state_type;
	state_type state_ff, nxt_state;
	logic st_rise, st_fall;
	logic ck_rise, ck_fall;
	logic sel2_ff, nxt_sel2;
	logic short_read_ff, nxt_short_read;
	logic [WIDTH-1:0] pos_ff, nxt_pos, neg_ff, nxt_neg;
	logic [WIDTH-1:0] sar_ff, nxt_sar, trial_ff, nxt_trial;
	logic [WIDTH-1:0] shift_ff, nxt_shift;
	logic [BIT_CNT_W-1:0] cnt_ff, nxt_cnt;
	logic [TIMER_W-1:0] osc_ff, nxt_osc;
	logic dout_ff, nxt_dout, oe_ff, nxt_oe;
	logic [WIDTH:0] diff;

	edge_sync u_start (.i_clk(I_MCLK), .i_rst(I_SYS_RST),
		.i_async(LINK.conversion_start_pin), .o_level(),
		.o_rise(st_rise), .o_fall(st_fall));
	edge_sync u_sclk (.i_clk(I_MCLK), .i_rst(I_SYS_RST),
		.i_async(LINK.sclk), .o_level(),
		.o_rise(ck_rise), .o_fall(ck_fall));

	// Bipolar sign-extends both inputs before taking the difference
	always_comb begin
		diff = {1'b0, pos_ff} - {1'b0, neg_ff}; // R3
		if (sel2_ff && DIFFERENTIAL)
			diff = {pos_ff[WIDTH-1], pos_ff} - {neg_ff[WIDTH-1], neg_ff};
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_sel2 = sel2_ff;
		nxt_short_read = short_read_ff;
		nxt_pos = pos_ff;
		nxt_neg = neg_ff;
		nxt_sar = sar_ff;
		nxt_trial = trial_ff;
		nxt_shift = shift_ff;
		nxt_cnt = cnt_ff;
		nxt_osc = osc_ff;
		nxt_dout = dout_ff;
		nxt_oe = oe_ff;
		case (state_ff)
			ST_SHUTDOWN: begin
				if (st_rise) begin
					nxt_state = ST_TRACK; // R1
					nxt_sel2 = short_read_ff; // R16 R11
					nxt_dout = 1'b0; // R5
					nxt_oe = 1'b1;
					nxt_osc = TIMER_ZERO;
				end
			end
			ST_TRACK: begin
				// High time since the latest rise; saturates on long holds
				if (osc_ff != {TIMER_W{1'b1}})
					nxt_osc = osc_ff + 12'h001;
				// Second rise while tracking marks the double pulse
				if (st_rise) begin
					nxt_sel2 = 1'b1; // R12 R17
					nxt_osc = TIMER_ZERO;
				end
				// Track follows the selected channel until hold
				if (DIFFERENTIAL) begin
					nxt_pos = I_POSITIVE_DIFF_INPUT; // R4
					nxt_neg = I_NEGATIVE_DIFF_INPUT;
				end else begin
					nxt_pos = sel2_ff ? I_SECOND_INPUT_CHANNEL
						: I_FIRST_INPUT_CHANNEL; // R4
					nxt_neg = RESULT_ZERO;
				end
				// Short high is the first half of a double pulse, not a hold;
				// half the least acquisition time leaves margin both ways
				if (st_fall && osc_ff >= TIMER_W'(ACQ_MIN_CYCLES / 2)) begin
					nxt_cnt = BIT_CNT_ZERO;
					nxt_sar = RESULT_ZERO;
					nxt_trial = {1'b1, {(WIDTH-1){1'b0}}};
					nxt_osc = TIMER_ZERO;
					nxt_pos = pos_ff;
					nxt_neg = neg_ff;
					nxt_state = ST_CONVERT; // R2
				end
			end
			ST_CONVERT: begin
				nxt_osc = osc_ff + 12'h001;
				if (osc_ff == TIMER_W'(SAR_STEP_CYCLES - 1)) begin // R18
					nxt_osc = TIMER_ZERO;
					if ((sar_ff | trial_ff) <= diff[WIDTH-1:0])
						nxt_sar = sar_ff | trial_ff;
					nxt_trial = trial_ff >> 1;
					if (trial_ff == RESULT_ZERO) begin
						nxt_shift = sar_ff;
						nxt_dout = sar_ff[WIDTH-1]; // R5 R6
						nxt_state = ST_SHIFT; // R7
						nxt_short_read = 1'b1;
					end
				end
			end
			ST_SHIFT: begin
				if (ck_fall && cnt_ff != BIT_CNT_ZERO) begin
					nxt_shift = {shift_ff[WIDTH-2:0], 1'b0}; // R9
					nxt_dout = shift_ff[WIDTH-2]; // R8
				end
				if (ck_rise) begin
					nxt_cnt = cnt_ff + 4'h1;
					if (cnt_ff == BIT_CNT_W'(WIDTH - 1)) begin
						nxt_oe = 1'b0; // R10
						nxt_short_read = 1'b0; // R15
						nxt_state = ST_SHUTDOWN;
					end
				end
				if (st_rise) begin
					nxt_oe = 1'b1;
					nxt_dout = 1'b0;
					nxt_sel2 = 1'b1; // R16
					nxt_osc = TIMER_ZERO;
					nxt_state = ST_TRACK;
				end
			end
			default: nxt_state = ST_SHUTDOWN;
		endcase
	end

	always_ff @(posedge I_MCLK) begin
		if (I_SYS_RST) begin
			state_ff <= ST_SHUTDOWN;
			sel2_ff <= 1'b0;
			short_read_ff <= 1'b0;
			pos_ff <= RESULT_ZERO;
			neg_ff <= RESULT_ZERO;
			sar_ff <= RESULT_ZERO;
			trial_ff <= RESULT_ZERO;
			shift_ff <= RESULT_ZERO;
			cnt_ff <= BIT_CNT_ZERO;
			osc_ff <= TIMER_ZERO;
			dout_ff <= 1'b0;
			oe_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			sel2_ff <= nxt_sel2;
			short_read_ff <= nxt_short_read;
			pos_ff <= nxt_pos;
			neg_ff <= nxt_neg;
			sar_ff <= nxt_sar;
			trial_ff <= nxt_trial;
			shift_ff <= nxt_shift;
			cnt_ff <= nxt_cnt;
			osc_ff <= nxt_osc;
			dout_ff <= nxt_dout;
			oe_ff <= nxt_oe;
		end
	end

	assign LINK.dout_o = dout_ff;
	assign LINK.dout_oe = oe_ff;
	assign O_POWERED = (state_ff == ST_TRACK) || (state_ff == ST_CONVERT);
	assign O_TRACKING = (state_ff == ST_TRACK);
	assign O_SECOND_SELECT = sel2_ff;
	assign O_BIPOLAR = sel2_ff & DIFFERENTIAL;
endmodule
`default_nettype wire

/* File: core/adc_host.sv */
// Host end: pulses the start pin, waits out conversion, reads 12 bits.
// Assumes a one-cycle request pulse on the user side.
`timescale 1ns/1ps
`default_nettype none
module adc_host
	import adc_link_pkg::*;
#(
	parameter int ACQ_CYCLES = ACQ_MIN_CYCLES,
	parameter int WIDTH = RESULT_BITS
) (
	// System
	input wire logic I_MCLK,
	input wire logic I_SYS_RST,
	// Link
	adc_link_if.host LINK,
	// User request
	input wire logic I_START,
	input wire logic I_SECOND,
	output logic O_BUSY,
	// Result
	output logic [WIDTH-1:0] O_DATA,
	output logic O_VALID
);
	typedef enum {H_IDLE, H_PULSE_HI, H_PULSE_LO, H_ACQ, H_WAIT,
		H_CLK_LO, H_CLK_HI, H_DONE} hstate_type;
	hstate_type st_ff, nxt_st;
	logic cs_ff, nxt_cs, sclk_ff, nxt_sclk, valid_ff, nxt_valid;
	logic d_meta_ff, d_sync_ff;
	logic [TIMER_W-1:0] tmr_ff, nxt_tmr;
	logic [BIT_CNT_W-1:0] cnt_ff, nxt_cnt;
	logic [WIDTH-1:0] data_ff, nxt_data;
	logic tmr_done;

	assign tmr_done = (tmr_ff == TIMER_ZERO);

	always_comb begin
		nxt_st = st_ff;
		nxt_cs = cs_ff;
		nxt_sclk = sclk_ff;
		nxt_valid = 1'b0;
		nxt_tmr = tmr_done ? TIMER_ZERO : tmr_ff - 12'h001;
		nxt_cnt = cnt_ff;
		nxt_data = data_ff;
		case (st_ff)
			H_IDLE: if (I_START) begin
				nxt_cs = 1'b1; // R11
				nxt_st = I_SECOND ? H_PULSE_HI : H_ACQ;
				nxt_tmr = I_SECOND ? TIMER_W'(START_PULSE_CYCLES)
					: TIMER_W'(ACQ_CYCLES); // R13 R14
			end
			H_PULSE_HI: if (tmr_done) begin
				nxt_cs = 1'b0; // R12
				nxt_tmr = TIMER_W'(START_PULSE_CYCLES);
				nxt_st = H_PULSE_LO;
			end
			H_PULSE_LO: if (tmr_done) begin
				nxt_cs = 1'b1;
				nxt_tmr = TIMER_W'(ACQ_CYCLES);
				nxt_st = H_ACQ;
			end
			H_ACQ: if (tmr_done) begin
				nxt_cs = 1'b0;
				// Margin covers the device's input synchroniser
				nxt_tmr = TIMER_W'(CONV_CYCLES + 8);
				nxt_st = H_WAIT;
			end
			H_WAIT: if (tmr_done) begin
				nxt_cnt = BIT_CNT_ZERO;
				nxt_tmr = TIMER_W'(SCLK_HALF_CYCLES);
				nxt_st = H_CLK_LO;
			end
			H_CLK_LO: if (tmr_done) begin
				nxt_sclk = 1'b1;
				nxt_data = {data_ff[WIDTH-2:0], d_sync_ff}; // R19
				nxt_tmr = TIMER_W'(SCLK_HALF_CYCLES);
				nxt_st = H_CLK_HI;
			end
			H_CLK_HI: if (tmr_done) begin
				nxt_sclk = 1'b0;
				nxt_cnt = cnt_ff + 4'h1;
				nxt_tmr = TIMER_W'(SCLK_HALF_CYCLES);
				nxt_st = (cnt_ff == BIT_CNT_W'(WIDTH - 1)) ? H_DONE
					: H_CLK_LO; // R15
			end
			H_DONE: begin
				nxt_valid = 1'b1;
				nxt_st = H_IDLE;
			end
			default: nxt_st = H_IDLE;
		endcase
	end

	always_ff @(posedge I_MCLK) begin
		if (I_SYS_RST) begin
			st_ff <= H_IDLE;
			cs_ff <= 1'b0;
			sclk_ff <= 1'b0;
			valid_ff <= 1'b0;
			tmr_ff <= TIMER_ZERO;
			cnt_ff <= BIT_CNT_ZERO;
			data_ff <= RESULT_ZERO;
			d_meta_ff <= 1'b0;
			d_sync_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			cs_ff <= nxt_cs;
			sclk_ff <= nxt_sclk;
			valid_ff <= nxt_valid;
			tmr_ff <= nxt_tmr;
			cnt_ff <= nxt_cnt;
			data_ff <= nxt_data;
			d_meta_ff <= LINK.dout_wire;
			d_sync_ff <= d_meta_ff;
		end
	end

	assign LINK.conversion_start_pin = cs_ff;
	assign LINK.sclk = sclk_ff;
	assign O_BUSY = (st_ff != H_IDLE);
	assign O_DATA = data_ff;
	assign O_VALID = valid_ff;
endmodule
`default_nettype wire

/* File: verification/adc_link_asserts.sv */
// Checker for one converter link: start pin, data edges, release.
// Assumes both link ends run from I_MCLK and reset together.
`timescale 1ns/1ps
`default_nettype none
module adc_link_asserts
	import adc_link_pkg::*;
(
	// System
	input wire logic I_MCLK,
	input wire logic I_SYS_RST,
	// Link
	input wire logic conversion_start_pin,
	input wire logic sclk,
	input wire logic dout_o,
	input wire logic dout_oe
);
	logic start_ff, nxt_start, sclk_ff, nxt_sclk;
	logic [9:0] run_ff, nxt_run, fall_age_ff, nxt_fall_age;
	logic [3:0] rises_ff, nxt_rises;
	// Counters saturate so long idle gaps never wrap
	always_comb begin
		nxt_start = conversion_start_pin;
		nxt_sclk = sclk;
		nxt_run = run_ff;
		nxt_fall_age = fall_age_ff;
		nxt_rises = rises_ff;
		if (conversion_start_pin != start_ff)
			nxt_run = 10'h001;
		else if (run_ff != 10'h3ff)
			nxt_run = run_ff + 10'h001;
		if (start_ff && !conversion_start_pin)
			nxt_fall_age = 10'h001;
		else if (fall_age_ff != 10'h000 && fall_age_ff != 10'h3ff)
			nxt_fall_age = fall_age_ff + 10'h001;
		if (!start_ff && conversion_start_pin)
			nxt_rises = 4'h0;
		else if (sclk && !sclk_ff && rises_ff != 4'hf)
			nxt_rises = rises_ff + 4'h1;
	end
	always_ff @(posedge I_MCLK) begin
		start_ff <= I_SYS_RST ? 1'b0 : nxt_start;
		sclk_ff <= I_SYS_RST ? 1'b0 : nxt_sclk;
		run_ff <= I_SYS_RST ? 10'h000 : nxt_run;
		fall_age_ff <= I_SYS_RST ? 10'h000 : nxt_fall_age;
		rises_ff <= I_SYS_RST ? 4'h0 : nxt_rises;
	end
	default clocking cb @(posedge I_MCLK);
	endclocking
	default disable iff (I_SYS_RST);
	property p_power_track;
		$rose(conversion_start_pin) |-> ##[1:6] (dout_oe && !dout_o);
	endproperty
	a_power_track: assert property (p_power_track)
		else $error("data not driven low after start rise");
	property p_hold_low;
		$fell(conversion_start_pin) |=> (dout_oe && !dout_o) [*8];
	endproperty
	a_hold_low: assert property (p_hold_low)
		else $error("data not low at conversion start");
	property p_msb_time;
		(fall_age_ff == 10'h172) |-> (dout_oe && $stable(dout_o)) [*7];
	endproperty
	a_msb_time: assert property (p_msb_time)
		else $error("first bit not settled in time");
	property p_data_edge;
		(dout_oe && $past(dout_oe) && $changed(dout_o) &&
			fall_age_ff > 10'h174) |-> (!sclk && $past(sclk, 5));
	endproperty
	a_data_edge: assert property (p_data_edge)
		else $error("data changed away from a clock fall");
	property p_release;
		($rose(sclk) && rises_ff == 4'hb) |-> ##[1:6] !dout_oe;
	endproperty
	a_release: assert property (p_release)
		else $error("data not released after last bit");
	property p_full_read;
		$fell(dout_oe) |-> (rises_ff == 4'hc);
	endproperty
	a_full_read: assert property (p_full_read)
		else $error("data released with wrong bit count");
	property p_acq;
		$fell(conversion_start_pin) |-> (run_ff >= ACQ_MIN_CYCLES) or
			((run_ff >= START_PULSE_CYCLES) ##[1:8]
			$rose(conversion_start_pin));
	endproperty
	a_acq: assert property (p_acq)
		else $error("start high too short");
	property p_pulse_gap;
		$rose(conversion_start_pin) |-> (run_ff >= START_PULSE_CYCLES);
	endproperty
	a_pulse_gap: assert property (p_pulse_gap)
		else $error("start low too short");
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// Bench: host against a single-ended device, and a differential
// device driven by the bench itself. Needs the core files compiled.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import adc_link_pkg::*;
	logic I_MCLK, I_SYS_RST, start, second, busy, valid;
	logic powered, powered_b, sel2, bip_b, tracking, bip_a, sel2_b;
	logic [11:0] data, ch1, ch2, pos, neg, got;
	int num_errors, cmp_count;
	adc_link_if link_a();
	adc_link_if link_b();
	adc_host u_adc_host(.I_MCLK(I_MCLK), .I_SYS_RST(I_SYS_RST),
		.LINK(link_a), .I_START(start), .I_SECOND(second),
		.O_BUSY(busy), .O_DATA(data), .O_VALID(valid));
	adc_device u_adc_device(.I_MCLK(I_MCLK), .I_SYS_RST(I_SYS_RST),
		.LINK(link_a), .I_FIRST_INPUT_CHANNEL(ch1),
		.I_SECOND_INPUT_CHANNEL(ch2), .I_POSITIVE_DIFF_INPUT(pos),
		.I_NEGATIVE_DIFF_INPUT(neg), .O_POWERED(powered),
		.O_TRACKING(tracking), .O_SECOND_SELECT(sel2), .O_BIPOLAR(bip_a));
	adc_device #(.DIFFERENTIAL(1'b1)) u_adc_device_b(.I_MCLK(I_MCLK),
		.I_SYS_RST(I_SYS_RST), .LINK(link_b),
		.I_FIRST_INPUT_CHANNEL(ch1), .I_SECOND_INPUT_CHANNEL(ch2),
		.I_POSITIVE_DIFF_INPUT(pos), .I_NEGATIVE_DIFF_INPUT(neg),
		.O_POWERED(powered_b), .O_TRACKING(), .O_SECOND_SELECT(sel2_b),
		.O_BIPOLAR(bip_b));
	adc_link_asserts u_adc_link_asserts(.I_MCLK(I_MCLK),
		.I_SYS_RST(I_SYS_RST),
		.conversion_start_pin(link_a.conversion_start_pin),
		.sclk(link_a.sclk), .dout_o(link_a.dout_o),
		.dout_oe(link_a.dout_oe));
	initial begin
		I_MCLK = 1'b0;
		forever #5 I_MCLK = ~I_MCLK;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge I_MCLK);
		#1;
	endtask
	task automatic chk12(input string what, input logic [11:0] exp,
		input logic [11:0] seen);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic chk1(input string what, input logic exp,
		input logic seen);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %b seen %b", what, exp, seen);
		end
	endtask
	task automatic finish_test;
		if (num_errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	function automatic logic [11:0] expect_code(input logic [11:0] p,
		input logic [11:0] n);
		return p - n;
	endfunction
	task automatic wait_valid;
		int n;
		n = 0;
		while (valid !== 1'b1 && n < 2000) begin
			cyc(1);
			n++;
		end
		if (n == 2000) begin
			num_errors++;
			finish_test();
		end
	endtask
	// Bench acts as host on the second link; nbits below 12 is a short read
	task automatic bconv(input logic dbl, input int nbits);
		got = 12'h000;
		link_b.conversion_start_pin = 1'b1;
		cyc(5);
		if (dbl) begin
			link_b.conversion_start_pin = 1'b0;
			cyc(5);
			link_b.conversion_start_pin = 1'b1;
		end
		cyc(150);
		link_b.conversion_start_pin = 1'b0;
		cyc(380);
		// 80 ns serial clock; bit taken as the clock rises
		for (int i = 0; i < nbits; i++) begin
			link_b.sclk = 1'b1;
			got = {got[10:0], link_b.dout_wire};
			cyc(4);
			link_b.sclk = 1'b0;
			cyc(4);
		end
		cyc(10);
	endtask
	initial begin
		I_SYS_RST = 1'b1;
		start = 1'b0;
		second = 1'b0;
		{ch1, ch2, pos, neg} = 48'h0;
		link_b.conversion_start_pin = 1'b0;
		link_b.sclk = 1'b0;
		num_errors = 0;
		cmp_count = 0;
		void'($urandom(62));
		cyc(6);
		I_SYS_RST = 1'b0;
		cyc(10);
		for (int k = 0; k < 5; k++) begin
			ch1 = (k == 0) ? 12'hfff : 12'($urandom);
			ch2 = (k == 0) ? 12'h000 : 12'($urandom);
			second = (k < 2) ? k[0] : 1'($urandom);
			start = 1'b1;
			cyc(1);
			start = 1'b0;
			cyc(20);
			chk1("busy", 1'b1, busy);
			chk1("tracking", 1'b1, tracking);
			wait_valid();
			chk12("host_data", second ? ch2 : ch1, data);
			chk1("second_select", second, sel2);
			chk1("idle", 1'b0, busy);
			chk1("single_ended", 1'b0, bip_a);
			cyc(10);
			chk1("powered", 1'b0, powered);
		end
		pos = 12'($urandom);
		neg = 12'($urandom);
		bconv(1'b0, 12);
		chk12("diff_uni", expect_code(pos, neg), got);
		chk1("bipolar_uni", 1'b0, bip_b);
		chk1("released", 1'b0, link_b.dout_oe);
		chk1("powered_b", 1'b0, powered_b);
		bconv(1'b1, 12);
		chk12("diff_bip", expect_code(pos, neg), got);
		chk1("bipolar_dbl", 1'b1, bip_b);
		chk1("second_b", 1'b1, sel2_b);
		bconv(1'b0, 5);
		chk1("held", 1'b1, link_b.dout_oe);
		chk12("partial", expect_code(pos, neg) >> 7, got);
		bconv(1'b0, 12);
		chk1("bipolar_short", 1'b1, bip_b);
		chk12("diff_short", expect_code(pos, neg), got);
		bconv(1'b0, 12);
		chk1("bipolar_back", 1'b0, bip_b);
		finish_test();
	end
endmodule
`default_nettype wire
